// ==== verilog/drive_prot_cfg.svh ====
`ifndef DRIVE_PROT_CFG_SVH
`define DRIVE_PROT_CFG_SVH

// register offsets (word index on the plain port)
`define REG_FAN_MODE        4'h0
`define REG_FAN_THRESH      4'h1
`define REG_FAN_USAGE       4'h2
`define REG_FAN_CLEAR       4'h3
`define REG_UV_DELAY        4'h4
`define REG_IN_FUNC         4'h5
`define REG_OUT_FUNC        4'h6
`define REG_STATUS          4'h7
`define REG_CAPT_FREQ       4'h8
`define REG_CAPT_CURR       4'h9
`define REG_CONTROL         4'ha

// function codes
`define FAN_MODE_TRIP       1'h0
`define FAN_MODE_WARN       1'h1
`define OUT_FN_FAN_WARN     6'h08
`define OUT_FN_UNDERVOLT    6'h0b
`define OUT_FN_FAN_EXCH     6'h25
`define IN_FN_RESET         6'h03
`define IN_FN_BLOCK         6'h05

// reset values and undervoltage delay limit
`define FAN_THRESH_RST      16'h0384
`define UV_DELAY_RST        10'h000
`define UV_DELAY_MAX        10'h258

// status bit positions
`define ST_FAN_TRIP         0
`define ST_UV_TRIP          1
`define ST_BLOCK            2
`define ST_FAN_WARN         3
`define ST_FAN_EXCH         4
`define ST_OVERHEAT_TRIP    5
`define ST_RUNNING          6
`define ST_UV_REPORT        7

// timing
`define CLK_HZ              125000000
`define TENTH_SEC_CYC       (`CLK_HZ / 10)
// fan life 50000 h; 0.1 % of it is 50 h
`define FAN_LIFE_HOURS      50000
`define FAN_STEP_SEC        (`FAN_LIFE_HOURS * 3600 / 1000)

`endif

// ==== verilog/drive_prot_pkg.sv ====
package drive_prot_pkg;
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_RUN     = 2'b01,
        ST_STOPPED = 2'b10
    } run_state_t;
endpackage

// ==== verilog/tick_divider.sv ====
`timescale 1ns/100ps
// one-cycle enable pulse every div cycles
module tick_divider #(
    parameter int unsigned DIV = 12500000
) (
    input  wire logic clk,
    input  wire logic nrst,
    output logic      tick
);
    logic [31:0] count;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count <= 32'h0000_0000;
            tick  <= 1'b0;
        end else if (count == DIV - 1) begin
            count <= 32'h0000_0000;
            tick  <= 1'b1;
        end else begin
            count <= count + 32'h0000_0001;
            tick  <= 1'b0;
        end
    end
endmodule

// ==== verilog/drive_fault_protection_logic.sv ====
`timescale 1ns/100ps
`include "drive_prot_cfg.svh"
//
// Contract
// [RULE1] fan mode 0: fan error blocks, trips
// [RULE2] fan mode 1: code 8 outputs, keep running
// [RULE3] overheat blocks output even in warn mode
// [RULE4] usage reaches threshold: exchange warning, code 37
// [RULE5] usage readable 0.0-6553.5 in tenths
// [RULE6] clear write of 1 zeroes usage
// [RULE7] undervoltage stops output, enters trip
// [RULE8] code 11 outputs after undervoltage delay
// [RULE9] code 5 input blocks output, indicates
// [RULE10] block captures frequency and current
// [RULE11] resume needs block off and new run
// [RULE12] code 3 input clears latched trips
// [RULE13] keypad stop/reset also clears trips
// [RULE14] usage counted from fan run time
module drive_fault_protection_logic #(
    parameter int unsigned TENTH_SEC_CYC = `TENTH_SEC_CYC,
    parameter int unsigned FAN_STEP_SEC  = `FAN_STEP_SEC
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata,
    input  wire logic [6:0]  input_terminal,
    input  wire logic        run_cmd,
    input  wire logic        key_stop_reset,
    input  wire logic        fan_error,
    input  wire logic        fan_running,
    input  wire logic        overheat,
    input  wire logic        undervoltage,
    input  wire logic [15:0] oper_freq,
    input  wire logic [15:0] oper_current,
    output logic      [2:0]  out_terminal,
    output logic             output_enable,
    output logic             keypad_fan_exchange,
    output logic      [1:0]  keypad_indication
);

    ////////////////////////////////////////////////////////////////////
    // configuration registers

    logic        fan_mode;
    logic [15:0] fan_thresh;
    logic [9:0]  undervoltage_report_delay;
    logic [5:0]  input_terminal_function [7];
    logic [5:0]  open_collector_function [3];
    logic [15:0] fan_usage;
    logic [15:0] capt_freq;
    logic [15:0] capt_curr;
    logic        fan_trip;
    logic        uv_trip;
    logic        oh_trip;
    logic        block_active;
    logic        fan_exch;
    logic        uv_report;
    logic        run_state_bit;
    logic        usage_clear;

    drive_prot_pkg::run_state_t state;
    drive_prot_pkg::run_state_t next_state;

    assign usage_clear = wr && addr == `REG_FAN_CLEAR && wdata[0];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fan_mode                  <= `FAN_MODE_TRIP;
            fan_thresh                <= `FAN_THRESH_RST;
            undervoltage_report_delay <= `UV_DELAY_RST;
        end else if (wr) begin
            unique case (addr)
                `REG_FAN_MODE:   fan_mode <= wdata[0];
                `REG_FAN_THRESH: fan_thresh <= wdata;
                `REG_UV_DELAY: begin
                    if (wdata[9:0] <= `UV_DELAY_MAX)
                        undervoltage_report_delay <= wdata[9:0];
                end
                default: ;
            endcase
        end
    end

    // function codes: in_func word holds slot in [14:12], code in [5:0]
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++) begin : g_in_fn
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst)
                    input_terminal_function[gi] <= 6'h00;
                else if (wr && addr == `REG_IN_FUNC && wdata[14:12] == gi[2:0])
                    input_terminal_function[gi] <= wdata[5:0];
            end
        end
        for (gi = 0; gi < 3; gi++) begin : g_out_fn
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst)
                    open_collector_function[gi] <= 6'h00;
                else if (wr && addr == `REG_OUT_FUNC && wdata[13:12] == gi[1:0])
                    open_collector_function[gi] <= wdata[5:0];
            end
        end
    endgenerate

    function automatic logic any_input_with(input logic [5:0] code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 7; i++)
            if (input_terminal_function[i] == code && input_terminal[i])
                hit = 1'b1;
        return hit;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // trips and resets

    logic block_in;
    logic trip_reset;
    logic fan_warn;

    // always_comb also follows the function tables the decoder reads
    always_comb begin
        block_in   = any_input_with(`IN_FN_BLOCK);
        trip_reset = any_input_with(`IN_FN_RESET) || key_stop_reset; // RULE12 RULE13
    end
    assign fan_warn   = fan_mode == `FAN_MODE_WARN && fan_error;

    // set wins over reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            fan_trip <= 1'b0;
        else if (fan_mode == `FAN_MODE_TRIP && fan_error)
            fan_trip <= 1'b1; // RULE1
        else if (trip_reset)
            fan_trip <= 1'b0;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            oh_trip <= 1'b0;
        else if (overheat)
            oh_trip <= 1'b1; // RULE3
        else if (trip_reset)
            oh_trip <= 1'b0;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            uv_trip <= 1'b0;
        else if (undervoltage)
            uv_trip <= 1'b1; // RULE7
        else if (trip_reset)
            uv_trip <= 1'b0;
    end

    // output block follows the input while running
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            block_active <= 1'b0;
        else if (block_in && state == drive_prot_pkg::ST_RUN)
            block_active <= 1'b1; // RULE9
        else if (!block_in)
            block_active <= 1'b0;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            capt_freq <= 16'h0000;
            capt_curr <= 16'h0000;
        end else if (block_in && state == drive_prot_pkg::ST_RUN && !block_active) begin
            capt_freq <= oper_freq; // RULE10
            capt_curr <= oper_current; // RULE10
        end
    end

    ////////////////////////////////////////////////////////////////////
    // run state

    logic any_stop;
    logic run_prev;
    logic run_edge;

    assign any_stop = fan_trip || oh_trip || uv_trip || block_in || block_active;
    assign run_edge = run_cmd && !run_prev;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            run_prev <= 1'b0;
        else
            run_prev <= run_cmd;
    end

    always_comb begin
        next_state = state;
        unique case (state)
            drive_prot_pkg::ST_IDLE:
                if (run_edge && !any_stop)
                    next_state = drive_prot_pkg::ST_RUN;
            drive_prot_pkg::ST_RUN:
                if (any_stop)
                    next_state = drive_prot_pkg::ST_STOPPED;
                else if (!run_cmd)
                    next_state = drive_prot_pkg::ST_IDLE;
            drive_prot_pkg::ST_STOPPED:
                if (run_edge && !any_stop)
                    next_state = drive_prot_pkg::ST_RUN; // RULE11
            default:
                next_state = drive_prot_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            state <= drive_prot_pkg::ST_IDLE;
        else
            state <= next_state;
    end

    assign run_state_bit = state == drive_prot_pkg::ST_RUN;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            output_enable <= 1'b0;
        else
            output_enable <= next_state == drive_prot_pkg::ST_RUN && !any_stop; // RULE1 RULE3 RULE7 RULE9
    end

    ////////////////////////////////////////////////////////////////////
    // tenth-second time base

    logic tenth_tick;

    tick_divider #(
        .DIV (TENTH_SEC_CYC)
    ) u_tenth (
        .clk  (clk),
        .nrst (nrst),
        .tick (tenth_tick)
    );

    // report delay in 0.1 s; extra tick covers the partial first tenth
    logic [9:0] uv_count;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            uv_count  <= 10'h000;
            uv_report <= 1'b0;
        end else if (!uv_trip) begin
            uv_count  <= 10'h000;
            uv_report <= 1'b0;
        end else if (undervoltage_report_delay == 10'h000 || uv_count > undervoltage_report_delay) begin
            uv_report <= 1'b1; // RULE8
        end else if (tenth_tick) begin
            uv_count <= uv_count + 10'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // fan usage: one 0.1 % step per 180000 s of fan run time

    logic [31:0] fan_tenths;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fan_tenths <= 32'h0000_0000;
            fan_usage  <= 16'h0000;
        end else if (usage_clear) begin
            fan_tenths <= 32'h0000_0000; // RULE6
            fan_usage  <= 16'h0000; // RULE6
        end else if (tenth_tick && fan_running) begin
            if (fan_tenths == FAN_STEP_SEC * 10 - 1) begin
                fan_tenths <= 32'h0000_0000;
                if (fan_usage != 16'hffff)
                    fan_usage <= fan_usage + 16'h0001; // RULE14 RULE5
            end else begin
                fan_tenths <= fan_tenths + 32'h0000_0001; // RULE14
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            fan_exch <= 1'b0;
        else
            fan_exch <= fan_usage >= fan_thresh; // RULE4
    end

    ////////////////////////////////////////////////////////////////////
    // outputs

    generate
        for (gi = 0; gi < 3; gi++) begin : g_out
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst)
                    out_terminal[gi] <= 1'b0;
                else
                    unique case (open_collector_function[gi])
                        `OUT_FN_FAN_WARN:  out_terminal[gi] <= fan_warn; // RULE2
                        `OUT_FN_UNDERVOLT: out_terminal[gi] <= uv_report; // RULE8
                        `OUT_FN_FAN_EXCH:  out_terminal[gi] <= fan_exch; // RULE4
                        default:           out_terminal[gi] <= 1'b0;
                    endcase
            end
        end
    endgenerate

    assign keypad_fan_exchange = fan_exch; // RULE4

    // 1 fan trip, 2 output block, 3 other trip
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            keypad_indication <= 2'h0;
        else if (fan_trip)
            keypad_indication <= 2'h1; // RULE1
        else if (block_active)
            keypad_indication <= 2'h2; // RULE9
        else if (uv_trip || oh_trip)
            keypad_indication <= 2'h3;
        else
            keypad_indication <= 2'h0;
    end

    ////////////////////////////////////////////////////////////////////
    // register read

    logic [15:0] status;

    always_comb begin
        status                    = 16'h0000;
        status[`ST_FAN_TRIP]      = fan_trip;
        status[`ST_UV_TRIP]       = uv_trip;
        status[`ST_BLOCK]         = block_active;
        status[`ST_FAN_WARN]      = fan_warn;
        status[`ST_FAN_EXCH]      = fan_exch;
        status[`ST_OVERHEAT_TRIP] = oh_trip;
        status[`ST_RUNNING]       = run_state_bit;
        status[`ST_UV_REPORT]     = uv_report;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            rdata <= 16'h0000;
        else if (rd)
            unique case (addr)
                `REG_FAN_MODE:   rdata <= {15'h0000, fan_mode};
                `REG_FAN_THRESH: rdata <= fan_thresh;
                `REG_FAN_USAGE:  rdata <= fan_usage; // RULE5
                `REG_UV_DELAY:   rdata <= {6'h00, undervoltage_report_delay};
                `REG_STATUS:     rdata <= status;
                `REG_CAPT_FREQ:  rdata <= capt_freq; // RULE10
                `REG_CAPT_CURR:  rdata <= capt_curr; // RULE10
                `REG_IN_FUNC:    rdata <= {10'h000, input_terminal_function[0]};
                `REG_OUT_FUNC:   rdata <= {10'h000, open_collector_function[0]};
                default:         rdata <= 16'h0000;
            endcase
        else
            rdata <= 16'h0000;
    end

endmodule

// ==== testbench/drive_fault_protection_logic_chk.sv ====
`timescale 1ns/100ps
module drive_fault_protection_logic_chk #(
    parameter int unsigned TENTH_SEC_CYC = 10,
    parameter int unsigned FAN_STEP_SEC  = 2
) (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic [3:0]  addr,
    input wire logic        rd,
    input wire logic [15:0] rdata,
    input wire logic [6:0]  input_terminal,
    input wire logic        run_cmd,
    input wire logic        key_stop_reset,
    input wire logic        fan_error,
    input wire logic        overheat,
    input wire logic        undervoltage,
    input wire logic        output_enable,
    input wire logic [1:0]  keypad_indication
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////
    AST_RD_IDLE: assert property (!$past(rd) |-> rdata == 16'h0000)
        else $error("read data outside read slot");
    AST_UNMAPPED: assert property (rd && addr > 4'ha |=> rdata == 16'h0000)
        else $error("unmapped read not zero");
    AST_UV_STOP: assert property (undervoltage [*3] |-> !output_enable)
        else $error("driving during undervoltage");
    AST_UV_IND: assert property (undervoltage [*3] |-> keypad_indication != 2'h0)
        else $error("undervoltage not indicated");
    AST_OH_STOP: assert property (overheat [*3] |-> !output_enable)
        else $error("driving during overheat");
    AST_IND_OFF: assert property ((keypad_indication != 2'h0) [*2] |-> !output_enable)
        else $error("driving while trip or block shown");
    AST_KEY_CLEAR: assert property ((key_stop_reset && !fan_error && !overheat && !undervoltage) [*3]
        |-> keypad_indication inside {2'h0, 2'h2}) else $error("key did not clear trip");
    AST_TRIP_LATCH: assert property (keypad_indication == 2'h1 && !key_stop_reset && input_terminal == 7'h00
        && !overheat && !undervoltage |=> keypad_indication == 2'h1) else $error("fan trip lost");
    AST_RUN_EDGE: assert property ($rose(output_enable) |-> $past(run_cmd))
        else $error("start without run command");
    ////////////////////////////////////////
    cover property (keypad_indication == 2'h1);
    cover property (keypad_indication == 2'h2);
    cover property (undervoltage && keypad_indication == 2'h3);
endmodule

// ==== testbench/drive_partner.sv ====
`timescale 1ns/100ps
// operator and terminal wiring, levels launched after the edge
module drive_partner (
    input  wire logic       clk,
    input  wire logic [6:0] want_in,
    input  wire logic       want_run,
    input  wire logic       want_key,
    output logic      [6:0] input_terminal = 7'h00,
    output logic            run_cmd = 1'b0,
    output logic            key_stop_reset = 1'b0
);
    always @(posedge clk) begin
        input_terminal <= want_in;
        run_cmd <= want_run;
        key_stop_reset <= want_key;
    end
endmodule

// ==== testbench/drive_fault_protection_logic_tb.sv ====
`timescale 1ns/100ps
`include "drive_prot_cfg.svh"
module drive_fault_protection_logic_tb;
    localparam int TS = 10;
    localparam int FS = 2;
    localparam int STEP = FS * 10 * TS;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [15:0] rdata;
    logic [6:0]  want_in = 7'h00;
    logic        want_run = 1'b0;
    logic        want_key = 1'b0;
    logic [6:0]  input_terminal;
    logic        run_cmd;
    logic        key_stop_reset;
    logic        fan_error = 1'b0;
    logic        fan_running = 1'b0;
    logic        overheat = 1'b0;
    logic        undervoltage = 1'b0;
    logic [15:0] oper_freq = 16'h0000;
    logic [15:0] oper_current = 16'h0000;
    logic [2:0]  out_terminal;
    logic        output_enable;
    logic        keypad_fan_exchange;
    logic [1:0]  keypad_indication;
    logic [31:0] seed = 32'h00011ab6;
    logic [15:0] d;
    int          miscompares = 0;
    int          num_checks = 0;
    int          i;

    always #4 clk = ~clk;

    drive_partner op_u (.clk, .want_in, .want_run, .want_key, .input_terminal, .run_cmd, .key_stop_reset);
    drive_fault_protection_logic #(.TENTH_SEC_CYC(TS), .FAN_STEP_SEC(FS)) dut_u (
        .clk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .input_terminal, .run_cmd, .key_stop_reset,
        .fan_error, .fan_running, .overheat, .undervoltage, .oper_freq, .oper_current,
        .out_terminal, .output_enable, .keypad_fan_exchange, .keypad_indication);
    ////////////////////////////////////////
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [15:0] slot_code(input logic [2:0] s, input logic [5:0] c);
        return {1'b0, s, 6'h00, c};
    endfunction
    task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t bit %b expected %b", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk_reg(rdata, exp);
    endtask
    task automatic wait_oe(input logic v);
        int k;
        k = 0;
        while (output_enable !== v && k < 40) begin
            @(posedge clk);
            #1;
            k++;
        end
        chk_bit(output_enable, v);
    endtask
    task automatic restart;
        want_run <= 1'b0;
        repeat (3) @(posedge clk);
        want_run <= 1'b1;
        wait_oe(1'b1);
    endtask
    task automatic pulse_key;
        want_key <= 1'b1;
        repeat (4) @(posedge clk);
        want_key <= 1'b0;
    endtask
    task automatic wrap_up;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        #160000;
        miscompares++;
        $display("[ERR] %0t watchdog expired", $time);
        wrap_up();
    end

    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        rd_reg(`REG_FAN_MODE, 16'h0000);
        rd_reg(`REG_FAN_THRESH, `FAN_THRESH_RST);
        rd_reg(`REG_FAN_USAGE, 16'h0000);
        rd_reg(`REG_UV_DELAY, 16'h0000);
        rd_reg(4'hf, 16'h0000);
        $display("test reset done");
        restart();
        fan_error <= 1'b1;
        wait_oe(1'b0);
        chk_reg({14'h0, keypad_indication}, 16'h0001);
        fan_error <= 1'b0;
        pulse_key();
        #1 chk_reg({14'h0, keypad_indication}, 16'h0000);
        $display("test fan trip done");
        wr_reg(`REG_FAN_MODE, 16'h0001);
        wr_reg(`REG_OUT_FUNC, slot_code(3'h0, `OUT_FN_FAN_WARN));
        wr_reg(`REG_OUT_FUNC, slot_code(3'h1, `OUT_FN_UNDERVOLT));
        wr_reg(`REG_OUT_FUNC, slot_code(3'h2, `OUT_FN_FAN_EXCH));
        wr_reg(`REG_IN_FUNC, slot_code(3'h1, `IN_FN_RESET));
        wr_reg(`REG_IN_FUNC, slot_code(3'h2, `IN_FN_BLOCK));
        rd_reg(`REG_OUT_FUNC, 16'h0008);
        restart();
        fan_error <= 1'b1;
        repeat (4) @(posedge clk);
        #1 chk_bit(out_terminal[0], 1'b1);
        chk_bit(output_enable, 1'b1);
        overheat <= 1'b1;
        wait_oe(1'b0);
        fan_error <= 1'b0;
        overheat <= 1'b0;
        want_in <= 7'h02;
        repeat (4) @(posedge clk);
        want_in <= 7'h00;
        #1 chk_reg({14'h0, keypad_indication}, 16'h0000);
        $display("test fan warn done");
        for (i = 0; i < 2; i++) begin
            seed = nxt(seed);
            d = {13'h0, seed[2:0]} + 16'h0001;
            wr_reg(`REG_UV_DELAY, d);
            wr_reg(`REG_UV_DELAY, 16'h0259);
            rd_reg(`REG_UV_DELAY, d);
            restart();
            undervoltage <= 1'b1;
            repeat (int'(d) * TS + 3) @(posedge clk);
            #1 chk_bit(out_terminal[1], 1'b0);
            repeat (10) @(posedge clk);
            #1 chk_bit(out_terminal[1], 1'b1);
            chk_bit(output_enable, 1'b0);
            chk_reg({14'h0, keypad_indication}, 16'h0003);
            undervoltage <= 1'b0;
            pulse_key();
        end
        $display("test undervoltage done");
        restart();
        seed = nxt(seed);
        oper_freq <= seed[15:0];
        oper_current <= seed[31:16];
        want_in <= 7'h04;
        wait_oe(1'b0);
        @(posedge clk);
        #1 chk_reg({14'h0, keypad_indication}, 16'h0002);
        oper_freq <= ~seed[15:0];
        rd_reg(`REG_CAPT_FREQ, seed[15:0]);
        rd_reg(`REG_CAPT_CURR, seed[31:16]);
        rd_reg(`REG_STATUS, 16'h0001 << `ST_BLOCK);
        want_in <= 7'h00;
        repeat (10) @(posedge clk);
        #1 chk_bit(output_enable, 1'b0);
        restart();
        $display("test block done");
        wr_reg(`REG_FAN_THRESH, 16'h0003);
        fan_running <= 1'b1;
        for (i = 0; i < 4 * STEP && keypad_fan_exchange !== 1'b1; i++)
            @(posedge clk);
        fan_running <= 1'b0;
        chk_bit(i >= 2 * STEP, 1'b1);
        @(posedge clk);
        #1 chk_bit(keypad_fan_exchange, 1'b1);
        chk_bit(out_terminal[2], 1'b1);
        rd_reg(`REG_FAN_USAGE, 16'h0003);
        wr_reg(`REG_FAN_CLEAR, 16'h0001);
        rd_reg(`REG_FAN_USAGE, 16'h0000);
        chk_bit(keypad_fan_exchange, 1'b0);
        $display("test fan usage done");
        wrap_up();
    end
endmodule

bind drive_fault_protection_logic drive_fault_protection_logic_chk #(
    .TENTH_SEC_CYC(TENTH_SEC_CYC), .FAN_STEP_SEC(FAN_STEP_SEC)) chk_u (
    .clk, .nrst, .addr, .rd, .rdata, .input_terminal, .run_cmd, .key_stop_reset, .fan_error,
    .overheat, .undervoltage, .output_enable, .keypad_indication);
